// [testbench/syc_sibling_model.sv]
`timescale 1ns/1ps
module syc_sibling_model (
  // synthesizer clock in, sibling clocks and tick out
  input wire logic clk_i,
  output logic clk_a_o,
  output logic clk_b_o,
  output logic clk_d_o,
  output logic lf_tick_o
);
  int cnt = 0;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  logic d_q = 1'b0;
  logic tick_q = 1'b0;
  // sibling periods of 5, 7 and 9 synthesizer cycles, edges kept away from clk_i edges
  initial
  begin
    #2;
    forever #20 a_q = ~a_q;
  end
  initial
  begin
    #2;
    forever #28 b_q = ~b_q;
  end
  initial
  begin
    #2;
    forever #36 d_q = ~d_q;
  end
  // low-frequency tick, one cycle in ten
  always @(posedge clk_i)
  begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    tick_q <= (cnt == 9);
  end
  assign clk_a_o = a_q;
  assign clk_b_o = b_q;
  assign clk_d_o = d_q;
  assign lf_tick_o = tick_q;
endmodule

// [testbench/synth_post_divider_c_output_tb.sv]
`timescale 1ns/1ps
module synth_post_divider_c_output_tb;
  import syc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic clk_a_i, clk_b_i, clk_d_i, lf_tick_i, out_o, frame_bound_o;
  logic [23:0] divider_c_value_o;
  int error_cnt = 0;
  int tests_run = 0;
  int hi, lo;
  int bnd_cnt = 0;
  always #4 clk_i = ~clk_i;
  // count frame boundary strobes
  always @(posedge clk_i)
  begin
    if (frame_bound_o === 1'b1)
      bnd_cnt <= bnd_cnt + 1;
  end
  syc_sibling_model u_syc_sibling_model (.clk_i(clk_i), .clk_a_o(clk_a_i), .clk_b_o(clk_b_i),
    .clk_d_o(clk_d_i), .lf_tick_o(lf_tick_i));
  syc_divider_c u_syc_divider_c (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .clk_a_i(clk_a_i),
    .clk_b_i(clk_b_i), .clk_d_i(clk_d_i), .lf_tick_i(lf_tick_i), .out_o(out_o),
    .frame_bound_o(frame_bound_o), .divider_c_value_o(divider_c_value_o));
  task automatic chk(logic [31:0] got, int lo_b, int hi_b);
    logic ok;
    ok = (got >= lo_b) && (got <= hi_b);
    tests_run++;
    if (ok !== 1'b1)
    begin
      $display("unexpected t=%0t got %h exp %h", $time, got, lo_b);
      error_cnt++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask
  // address taken at the next edge, registered byte looked at after it
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic cfg(logic [23:0] w);
    wr(CFG_ADDR_HI, w[23:16]);
    wr(CFG_ADDR_MID, w[15:8]);
    wr(CFG_ADDR_LO, w[7:0]);
    #1;
  endtask
  // count cycles while out_o holds level v
  task automatic span(logic v, output int c);
    c = 0;
    while (out_o === v && c < 3000)
    begin
      @(negedge clk_i);
      c++;
    end
  endtask
  task automatic meas();
    span(1'b1, hi);
    span(1'b0, lo);
    span(1'b1, hi);
    span(1'b0, lo);
  endtask
  task automatic t_reset();
    chk({8'h00, divider_c_value_o}, 32'h40, 32'h40);
    chk({24'h0, rdata_o}, 0, 0);
    meas();
    chk(hi + lo, 64, 64);
    chk(hi, 32, 32);
    $display("done reset");
  endtask
  task automatic t_regular();
    int dv[5] = '{7, 8, 41, 259, 3};
    int b0;
    b0 = bnd_cnt;
    cfg(24'h000004);
    for (int i = 0; i < 5; i++)
    begin
      @(negedge clk_i);
      chk({31'h0, out_o}, (i == 2 || i == 3) ? 0 : 1, (i == 2 || i == 3) ? 0 : 1);
    end
    foreach (dv[i])
    begin
      cfg(dv[i][23:0]);
      meas();
      chk(hi, dv[i] / 2, dv[i] / 2);
      chk(lo, dv[i] - dv[i] / 2, dv[i] - dv[i] / 2);
    end
    repeat (40) @(negedge clk_i);
    chk(bnd_cnt - b0, 0, 0);
    $display("done regular");
  endtask
  task automatic t_lf();
    logic [7:0] rb;
    cfg(24'h000008);
    wr(CFG_ADDR_HI, 8'hF2);
    wr(CFG_ADDR_MID, 8'h00);
    rd(CFG_ADDR_HI, rb);
    chk({24'h0, rb}, 32'hF2, 32'hF2);
    rd(8'h00, rb);
    chk({24'h0, rb}, 0, 0);
    meas();
    chk(hi, 4, 4);
    chk({8'h00, divider_c_value_o}, 8, 8);
    wr(CFG_ADDR_LO, 8'h04);
    #1;
    chk({8'h00, divider_c_value_o}, 32'hF20004, 32'hF20004);
    meas();
    chk(hi, 20, 20);
    chk(lo, 20, 20);
    $display("done lowfreq");
  endtask
  // cycles from pulse start to the frame boundary strobe
  task automatic bound_at(output int n);
    n = 0;
    span(1'b1, hi);
    while (frame_bound_o !== 1'b1 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic t_frame();
    int pr[3] = '{5, 7, 9};
    logic [1:0] sr[3] = '{SRC_A, SRC_B, SRC_D};
    int n;
    foreach (pr[i])
    begin
      cfg({MODE_SPECIAL, 2'b00, sr[i], 16'h0002});
      meas();
      chk(hi, pr[i] - 1, pr[i] + 1);
      chk(hi + lo, 2 * pr[i] - 1, 2 * pr[i] + 1);
    end
    cfg({MODE_SPECIAL, 2'b11, SRC_D, 16'h0002});
    meas();
    chk(lo, 8, 10);
    bound_at(n);
    chk(n, 0, 1);
    cfg({MODE_SPECIAL, 2'b01, SRC_D, 16'h0002});
    meas();
    bound_at(n);
    chk(n, 2, 7);
    $display("done frame");
  endtask
  task automatic results();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regular();
    t_lf();
    t_frame();
    results();
  end
  initial
  begin
    #200000;
    error_cnt++;
    results();
  end
endmodule

// [verilog/syc_divider_c.sv]
// Functional notes
// - in special mode with a non-low-frequency source, bits 15:0 count selected-clock periods between frame pulses.
// - in special mode with source 10, the output is a low-frequency clock of the tick rate over bits 15:0.
// - outside special mode the whole 24-bit word divides the synthesizer clock.
// - odd divisors near top output frequency may give duty down to about 33 percent.
// - duty stays within 45 to 55 percent for even divisors and odd divisors of 41 or more.
// - source select 00 picks clock A, 01 clock B, 10 the low-frequency clock, 11 clock D.
// - with bits 15:0 of 2 or more, each frame pulse is exactly one period of the selected sibling clock wide.
// - the four-bit mode field chooses frame pulse or low-frequency clock when all ones, else regular clock.
// - in frame mode polarity bit 0 gives a positive pulse and 1 a negative pulse.
// - in frame mode type 0 puts the frame boundary at the pulse centre, type 1 at its first edge.
`timescale 1ns/1ps
module syc_divider_c
  import syc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic wr_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // sibling post-divider clocks and low-frequency tick
  input wire logic clk_a_i,
  input wire logic clk_b_i,
  input wire logic clk_d_i,
  input wire logic lf_tick_i,
  // outputs
  output logic out_o,
  output logic frame_bound_o,
  output logic [23:0] divider_c_value_o
);

  function automatic logic is_special(input logic [23:0] c);
    is_special = (c[MODE_LSB +: 4] == MODE_SPECIAL);
  endfunction

  function automatic logic is_lf(input logic [23:0] c);
    is_lf = is_special(c) && (c[SRC_LSB +: 2] == SRC_LF);
  endfunction

  logic [23:0] stage_q, stage_d, cfg_q, cfg_d;
  logic [7:0] rdata_q, rdata_d;
  logic [NUM_SIB-1:0] sib_pin, s1_q, s2_q, s3_q, sib_q, sib_d, sib_rise, sib_fall;
  logic [23:0] div_cnt_q, div_cnt_d, dv, dv_half;
  logic div_out_q, div_out_d;
  logic [15:0] lf_cnt_q, lf_cnt_d, lv;
  logic lf_out_q, lf_out_d;
  logic [15:0] fp_cnt_q, fp_cnt_d, rv;
  logic fp_act_q, fp_act_d, bnd_q, bnd_d, out_q, out_d;
  logic sel_rise, sel_fall, cfg_chg;

  assign sib_pin = {clk_d_i, clk_b_i, clk_a_i};

  // three-stage synchronisers on the sibling clock pins
  genvar g;
  generate
    for (g = 0; g < NUM_SIB; g++)
    begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          sib_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= sib_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          sib_q[g] <= sib_d[g];
        end
      end
      // a level change counts only once the second and third stages agree
      assign sib_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : sib_q[g];
      assign sib_rise[g] = sib_d[g] & ~sib_q[g];
      assign sib_fall[g] = ~sib_d[g] & sib_q[g];
    end
  endgenerate

  // source select decode
  always_comb
  begin
    sel_rise = 1'b0;
    sel_fall = 1'b0;
    case (is_special(cfg_q) ? cfg_q[SRC_LSB +: 2] : SRC_LF)
      SRC_A:
      begin
        sel_rise = sib_rise[0];
        sel_fall = sib_fall[0];
      end
      SRC_B:
      begin
        sel_rise = sib_rise[1];
        sel_fall = sib_fall[1];
      end
      SRC_D:
      begin
        sel_rise = sib_rise[2];
        sel_fall = sib_fall[2];
      end
      default:
      begin
        sel_rise = 1'b0;
        sel_fall = 1'b0;
      end
    endcase
  end

  // register access: bytes stage, low byte commits the whole word
  always_comb
  begin
    stage_d = stage_q;
    cfg_d = cfg_q;
    rdata_d = BYTE_ZERO;
    if (wr_en_i)
    begin
      case (addr_i)
        CFG_ADDR_HI: stage_d[HI_LSB +: 8] = wdata_i;
        CFG_ADDR_MID: stage_d[MID_LSB +: 8] = wdata_i;
        CFG_ADDR_LO:
        begin
          stage_d[LO_LSB +: 8] = wdata_i;
          cfg_d = {stage_q[CFG_W-1:MID_LSB], wdata_i};
        end
        default: stage_d = stage_q;
      endcase
    end
    case (addr_i)
      CFG_ADDR_HI: rdata_d = stage_q[HI_LSB +: 8];
      CFG_ADDR_MID: rdata_d = stage_q[MID_LSB +: 8];
      CFG_ADDR_LO: rdata_d = stage_q[LO_LSB +: 8];
      default: rdata_d = BYTE_ZERO;
    endcase
  end

  assign cfg_chg = (cfg_d != cfg_q);

  // counters and output selection
  always_comb
  begin
    dv = (cfg_q < DIV_MIN) ? DIV_MIN : cfg_q;
    dv_half = dv >> 1;
    lv = (cfg_q[RATE_LSB +: 16] < LF_MIN) ? LF_MIN : cfg_q[RATE_LSB +: 16];
    rv = (cfg_q[RATE_LSB +: 16] < RATE_MIN) ? RATE_MIN : cfg_q[RATE_LSB +: 16];
    div_cnt_d = (div_cnt_q >= dv - 24'h000001) ? 24'h000000 : div_cnt_q + 24'h000001;
    div_out_d = (div_cnt_d < dv_half);
    lf_cnt_d = lf_cnt_q;
    if (lf_tick_i)
    begin
      lf_cnt_d = (lf_cnt_q >= lv - 16'h0001) ? 16'h0000 : lf_cnt_q + 16'h0001;
    end
    lf_out_d = (lf_cnt_d < (lv >> 1));
    fp_cnt_d = fp_cnt_q;
    fp_act_d = fp_act_q;
    bnd_d = 1'b0;
    if (sel_rise)
    begin
      if (fp_cnt_q >= rv - 16'h0001)
      begin
        fp_cnt_d = 16'h0000;
        fp_act_d = 1'b1;
        bnd_d = cfg_q[TYPE_BIT];
      end
      else
      begin
        fp_cnt_d = fp_cnt_q + 16'h0001;
        fp_act_d = 1'b0;
      end
    end
    else if (sel_fall && fp_act_q && !cfg_q[TYPE_BIT])
    begin
      bnd_d = 1'b1;
    end
    if (cfg_chg)
    begin
      div_cnt_d = 24'h000000;
      div_out_d = 1'b1;
      lf_cnt_d = 16'h0000;
      lf_out_d = 1'b1;
      fp_cnt_d = 16'h0000;
      fp_act_d = 1'b0;
      bnd_d = 1'b0;
    end
    if (!is_special(cfg_d))
    begin
      out_d = div_out_d;
    end
    else if (is_lf(cfg_d))
    begin
      out_d = lf_out_d;
    end
    else
    begin
      out_d = fp_act_d ^ cfg_d[POL_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_q <= CFG_RESET;
      cfg_q <= CFG_RESET;
      rdata_q <= BYTE_ZERO;
      div_cnt_q <= 24'h000000;
      div_out_q <= 1'b1;
      lf_cnt_q <= 16'h0000;
      lf_out_q <= 1'b1;
      fp_cnt_q <= 16'h0000;
      fp_act_q <= 1'b0;
      bnd_q <= 1'b0;
      out_q <= 1'b1;
    end
    else
    begin
      stage_q <= stage_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      div_cnt_q <= div_cnt_d;
      div_out_q <= div_out_d;
      lf_cnt_q <= lf_cnt_d;
      lf_out_q <= lf_out_d;
      fp_cnt_q <= fp_cnt_d;
      fp_act_q <= fp_act_d;
      bnd_q <= bnd_d;
      out_q <= out_d;
    end
  end

  assign rdata_o = rdata_q;
  assign out_o = out_q;
  assign frame_bound_o = bnd_q;
  assign divider_c_value_o = cfg_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cfg_commit_a: assert property (
    $changed(cfg_q) |-> $past(wr_en_i && (addr_i == CFG_ADDR_LO)))
    else $error("config changed without low byte write");
  div_wrap_a: assert property (
    (!is_special(cfg_q) && div_cnt_q == dv - 24'h000001 && !cfg_chg)
      |=> (div_cnt_q == 24'h000000) && div_out_q)
    else $error("divider did not wrap high");
  div_half_a: assert property (
    (!is_special(cfg_q) && div_cnt_q == dv_half - 24'h000001 && !cfg_chg)
      |=> !div_out_q && !out_o)
    else $error("divider did not fall at half count");
  reg_mode_a: assert property (
    !is_special(cfg_q) |-> (out_o == div_out_q))
    else $error("regular mode output mismatch");
  lf_mode_a: assert property (
    is_lf(cfg_q) |-> (out_o == lf_out_q) && !fp_act_q)
    else $error("low frequency output mismatch");
  pulse_pol_a: assert property (
    (is_special(cfg_q) && !is_lf(cfg_q)) |-> (out_o == (fp_act_q ^ cfg_q[POL_BIT])))
    else $error("frame pulse polarity wrong");
  pulse_hold_a: assert property (
    (fp_act_q && !sel_rise && !cfg_chg) |=> fp_act_q)
    else $error("frame pulse ended early");
  pulse_space_a: assert property (
    (fp_act_q && sel_rise && rv > RATE_MIN && !cfg_chg) |=> !fp_act_q [*2])
    else $error("frame pulse spacing wrong");
  bound_in_a: assert property (
    bnd_q |-> fp_act_q && $past(cfg_q[TYPE_BIT] ? sel_rise : sel_fall))
    else $error("frame boundary misplaced");
  bound_mode_a: assert property (
    bnd_q |-> is_special(cfg_q) && !is_lf(cfg_q))
    else $error("frame boundary outside frame mode");

  odd_div_c: cover property (!is_special(cfg_q) && dv[0] && $rose(div_out_q));
  lf_run_c: cover property (is_lf(cfg_q) && $fell(lf_out_q));
  frame_c: cover property (is_special(cfg_q) && bnd_q ##1 !fp_act_q);

endmodule

// [verilog/syc_pkg.sv]
package syc_pkg;
  // configuration word layout
  localparam int CFG_W = 24;
  localparam logic [23:0] CFG_RESET = 24'h000040;
  localparam logic [7:0] CFG_ADDR_HI = 8'h86;
  localparam logic [7:0] CFG_ADDR_MID = 8'h87;
  localparam logic [7:0] CFG_ADDR_LO = 8'h88;
  localparam int HI_LSB = 16;
  localparam int MID_LSB = 8;
  localparam int LO_LSB = 0;
  localparam int MODE_LSB = 20;
  localparam int TYPE_BIT = 19;
  localparam int POL_BIT = 18;
  localparam int SRC_LSB = 16;
  localparam int RATE_LSB = 0;
  localparam logic [3:0] MODE_SPECIAL = 4'hF;
  // source select codes
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_LF = 2'h2;
  localparam logic [1:0] SRC_D = 2'h3;
  // smallest usable counts
  localparam logic [23:0] DIV_MIN = 24'h000002;
  localparam logic [15:0] LF_MIN = 16'h0002;
  localparam logic [15:0] RATE_MIN = 16'h0001;
  localparam int NUM_SIB = 3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage
